// ---- src/crm_map.vh ----
// How it works
// - Two byte accumulators, first is high of word
// - Add, subtract, compare: second into first only
// - Decimal adjust acts on first accumulator only
// - Index plus 5/9/16-bit constant or accumulator
// - 16-bit stack pointer, stack grows downward
// - Push decrements, pull increments, per byte
// - Call pushes address of following instruction
// - Return reloads program counter from stack
// - Interrupt stacks next address, registers, vectors
// - 16-bit program counter advances per instruction
// - Flags: five status, two masks, stop mask
// - Half-carry, negative, zero, overflow, carry flags
// - Operations update flags from their results
// - Three code bytes queued before each instruction
// - Odd instruction lengths accepted without padding
// - Twenty-bit internal accumulator, 16-bit paths
// - Reset sets stop mask; set means stop ignored
// - Nonmaskable mask only set by reset or service
// - Masked requests are not latched, taken only while still held; service stacks then sets mask
// - Multi-byte values stored high byte first
`ifndef CRM_MAP_VH
`define CRM_MAP_VH

`define CRM_REG_D 5'h00
`define CRM_REG_X 5'h01
`define CRM_REG_Y 5'h02
`define CRM_REG_SP 5'h03
`define CRM_REG_PC 5'h04
`define CRM_REG_CCR 5'h05
`define CRM_REG_CMD 5'h06
`define CRM_REG_STATUS 5'h07
`define CRM_REG_OPERAND 5'h08
`define CRM_REG_EA 5'h09
`define CRM_REG_EXT_LO 5'h0a
`define CRM_REG_EXT_HI 5'h0b
`define CRM_REG_QUEUE_LO 5'h0c
`define CRM_REG_QUEUE_HI 5'h0d

`define CRM_OP_ADD 4'h0
`define CRM_OP_SUB 4'h1
`define CRM_OP_CMP 4'h2
`define CRM_OP_DAA 4'h3
`define CRM_OP_CALL 4'h4
`define CRM_OP_RET 4'h5
`define CRM_OP_RTI 4'h6
`define CRM_OP_EA 4'h7
`define CRM_OP_STOP 4'h8
`define CRM_OP_ADVANCE 4'h9
`define CRM_OP_MAC 4'ha

`define CRM_CCR_S 7
`define CRM_CCR_X 6
`define CRM_CCR_H 5
`define CRM_CCR_I 4
`define CRM_CCR_N 3
`define CRM_CCR_Z 2
`define CRM_CCR_V 1
`define CRM_CCR_C 0
`define CRM_CCR_RESET 8'hd0

`define CRM_FRAME_CALL_TOP 4'h1
`define CRM_FRAME_INT_TOP 4'h8
`define CRM_QUEUE_DEPTH 2'h3
`define CRM_PULL_CAPTURE 2'h2

`endif

// ---- src/crm_core.v ----
`timescale 1ns/100ps
`default_nettype none
`include "crm_map.vh"

module crm_core #(
    parameter [15:0] IRQ_VECTOR = 16'hfff0,
    parameter [15:0] NONMASKABLE_REQUEST_PIN_VECTOR = 16'hfff8
) (
    input wire clock,
    input wire rst,
    input wire [4:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    output reg [15:0] mem_addr,
    output reg [7:0] mem_wdata,
    output reg mem_wr,
    output reg mem_rd,
    input wire [7:0] mem_rdata,
    input wire irq_req,
    input wire nonmaskable_request_pin_n,
    output reg irq_ack,
    output reg osc_stop,
    input wire [7:0] code_data,
    input wire code_valid,
    output wire code_ready
);

    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_PUSH = 4'b0010;
    localparam [3:0] ST_PULL = 4'b0100;
    localparam [3:0] ST_WAITQ = 4'b1000;

    localparam [1:0] K_CALL = 2'h0;
    localparam [1:0] K_RET = 2'h1;
    localparam [1:0] K_INT = 2'h2;
    localparam [1:0] K_RTI = 2'h3;

    reg [7:0] acc_a_r;
    reg [7:0] acc_b_r;
    reg [15:0] idx_x_r;
    reg [15:0] idx_y_r;
    reg [15:0] stack_pointer_r;
    reg [15:0] program_counter_r;
    reg [7:0] flag_register_r;
    reg [15:0] operand_r;
    reg [15:0] ea_r;
    reg [19:0] ext_r;
    reg [3:0] state_r;
    reg [1:0] kind_r;
    reg nonmaskable_request_pin_r;
    reg [3:0] step_r;
    reg [1:0] phase_r;
    reg [1:0] adv_len_r;
    reg [23:0] q_r;
    reg [1:0] q_cnt_r;

    wire [15:0] acc_d = {acc_a_r, acc_b_r};
    // Sized net: inside a concatenation the product would shrink to 8 bits
    wire [15:0] mac_prod = acc_a_r * acc_b_r;
    wire x_mask = flag_register_r[`CRM_CCR_X];
    wire i_mask = flag_register_r[`CRM_CCR_I];
    wire nonmaskable_request_pin_take = !nonmaskable_request_pin_n && !x_mask;
    wire irq_take = irq_req && !i_mask;
    wire [3:0] cmd_op = reg_wdata[3:0];
    wire cmd_wr = reg_wr && (reg_addr == `CRM_REG_CMD);

    // Prefetch queue, entry 0 is the oldest byte
    wire q_full = (q_cnt_r == `CRM_QUEUE_DEPTH);
    wire consume = (state_r == ST_WAITQ) && q_full;
    wire [1:0] drop = consume ? adv_len_r : 2'h0;
    wire fill = code_valid && !q_full;
    wire [23:0] q_shift = q_r >> {drop, 3'h0};
    wire [1:0] q_cnt_nxt = q_cnt_r - drop + {1'b0, fill};
    wire [23:0] q_nxt;
    assign code_ready = !q_full;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1) begin : g_queue
            assign q_nxt[8*gi +: 8] = (fill && q_cnt_r == gi) ? code_data
                                                                : q_shift[8*gi +: 8];
        end
    endgenerate

    // Accumulator arithmetic, B the source except for decimal adjust
    reg [8:0] alu_sum;
    reg [8:0] alu_diff;
    reg [4:0] alu_half;
    reg daa_lo;
    reg daa_hi;
    reg [7:0] daa_res;
    reg [15:0] ea_nxt;
    reg [15:0] ea_base;
    reg [7:0] push_byte;
    reg [15:0] rd_mux;

    always @* begin
        alu_sum = {1'b0, acc_a_r} + {1'b0, acc_b_r};
        alu_diff = {1'b0, acc_a_r} - {1'b0, acc_b_r};
        alu_half = {1'b0, acc_a_r[3:0]} + {1'b0, acc_b_r[3:0]};
        daa_lo = flag_register_r[`CRM_CCR_H] || (acc_a_r[3:0] > 4'h9);
        daa_hi = flag_register_r[`CRM_CCR_C] || (acc_a_r > 8'h99);
        daa_res = acc_a_r + {1'b0, daa_hi, daa_hi, 2'h0, daa_lo, daa_lo, 1'b0};
    end

    always @* begin
        ea_base = operand_r[6] ? idx_y_r : idx_x_r;
        case (operand_r[15:14])
            2'h0: ea_nxt = ea_base + {{11{operand_r[4]}}, operand_r[4:0]};
            2'h1: ea_nxt = ea_base + {{7{operand_r[8]}}, operand_r[8:0]};
            2'h2: ea_nxt = ea_base + operand_r;
            default: begin
                case (operand_r[8:7])
                    2'h0: ea_nxt = ea_base + {8'h00, acc_a_r};
                    2'h1: ea_nxt = ea_base + {8'h00, acc_b_r};
                    default: ea_nxt = ea_base + acc_d;
                endcase
            end
        endcase
    end

    // Frame order: low index pushed first, so high bytes land lower
    always @* begin
        case (step_r)
            4'h0: push_byte = program_counter_r[7:0];
            4'h1: push_byte = program_counter_r[15:8];
            4'h2: push_byte = idx_y_r[7:0];
            4'h3: push_byte = idx_y_r[15:8];
            4'h4: push_byte = idx_x_r[7:0];
            4'h5: push_byte = idx_x_r[15:8];
            4'h6: push_byte = acc_a_r;
            4'h7: push_byte = acc_b_r;
            default: push_byte = flag_register_r;
        endcase
    end

    always @* begin
        case (reg_addr)
            `CRM_REG_D: rd_mux = acc_d;
            `CRM_REG_X: rd_mux = idx_x_r;
            `CRM_REG_Y: rd_mux = idx_y_r;
            `CRM_REG_SP: rd_mux = stack_pointer_r;
            `CRM_REG_PC: rd_mux = program_counter_r;
            `CRM_REG_CCR: rd_mux = {8'h00, flag_register_r};
            `CRM_REG_STATUS: rd_mux = {12'h000, q_cnt_r, osc_stop, state_r != ST_IDLE};
            `CRM_REG_OPERAND: rd_mux = operand_r;
            `CRM_REG_EA: rd_mux = ea_r;
            `CRM_REG_EXT_LO: rd_mux = ext_r[15:0];
            `CRM_REG_EXT_HI: rd_mux = {12'h000, ext_r[19:16]};
            `CRM_REG_QUEUE_LO: rd_mux = q_r[15:0];
            `CRM_REG_QUEUE_HI: rd_mux = {8'h00, q_r[23:16]};
            default: rd_mux = 16'h0000;
        endcase
    end

    always @(posedge clock) begin
        if (rst) begin
            acc_a_r <= 8'h00;
            acc_b_r <= 8'h00;
            idx_x_r <= 16'h0000;
            idx_y_r <= 16'h0000;
            stack_pointer_r <= 16'h0000;
            program_counter_r <= 16'h0000;
            flag_register_r <= `CRM_CCR_RESET;
            operand_r <= 16'h0000;
            ea_r <= 16'h0000;
            ext_r <= 20'h00000;
            state_r <= ST_IDLE;
            kind_r <= K_CALL;
            nonmaskable_request_pin_r <= 1'b0;
            step_r <= 4'h0;
            phase_r <= 2'h0;
            adv_len_r <= 2'h1;
            q_r <= 24'h000000;
            q_cnt_r <= 2'h0;
            reg_rdata <= 16'h0000;
            mem_addr <= 16'h0000;
            mem_wdata <= 8'h00;
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            irq_ack <= 1'b0;
            osc_stop <= 1'b0;
        end else begin
            mem_wr <= 1'b0;
            mem_rd <= 1'b0;
            irq_ack <= 1'b0;
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
            q_r <= q_nxt;
            q_cnt_r <= q_cnt_nxt;
            case (state_r)
                ST_IDLE: begin
                    if (reg_wr && !osc_stop) begin
                        case (reg_addr)
                            `CRM_REG_D: begin
                                acc_a_r <= reg_wdata[15:8];
                                acc_b_r <= reg_wdata[7:0];
                            end
                            `CRM_REG_X: idx_x_r <= reg_wdata;
                            `CRM_REG_Y: idx_y_r <= reg_wdata;
                            `CRM_REG_SP: stack_pointer_r <= reg_wdata;
                            `CRM_REG_PC: program_counter_r <= reg_wdata;
                            `CRM_REG_CCR: flag_register_r <= {reg_wdata[7],
                                reg_wdata[6] & x_mask, reg_wdata[5:0]};
                            `CRM_REG_OPERAND: operand_r <= reg_wdata;
                            `CRM_REG_EXT_LO: ext_r[15:0] <= reg_wdata;
                            `CRM_REG_EXT_HI: ext_r[19:16] <= reg_wdata[3:0];
                            default: ;
                        endcase
                        if (cmd_wr) begin
                            case (cmd_op)
                                `CRM_OP_ADD: begin
                                    acc_a_r <= alu_sum[7:0];
                                    flag_register_r[`CRM_CCR_H] <= alu_half[4];
                                    flag_register_r[`CRM_CCR_N] <= alu_sum[7];
                                    flag_register_r[`CRM_CCR_Z] <= (alu_sum[7:0] == 8'h00);
                                    flag_register_r[`CRM_CCR_V] <= (acc_a_r[7] == acc_b_r[7])
                                        && (alu_sum[7] != acc_a_r[7]);
                                    flag_register_r[`CRM_CCR_C] <= alu_sum[8];
                                end
                                `CRM_OP_SUB, `CRM_OP_CMP: begin
                                    if (cmd_op == `CRM_OP_SUB) begin
                                        acc_a_r <= alu_diff[7:0];
                                    end
                                    flag_register_r[`CRM_CCR_N] <= alu_diff[7];
                                    flag_register_r[`CRM_CCR_Z] <= (alu_diff[7:0] == 8'h00);
                                    flag_register_r[`CRM_CCR_V] <= (acc_a_r[7] != acc_b_r[7])
                                        && (alu_diff[7] != acc_a_r[7]);
                                    flag_register_r[`CRM_CCR_C] <= alu_diff[8];
                                end
                                `CRM_OP_DAA: begin
                                    acc_a_r <= daa_res;
                                    flag_register_r[`CRM_CCR_N] <= daa_res[7];
                                    flag_register_r[`CRM_CCR_Z] <= (daa_res == 8'h00);
                                    flag_register_r[`CRM_CCR_C] <=
                                        flag_register_r[`CRM_CCR_C] | daa_hi;
                                end
                                `CRM_OP_EA: ea_r <= ea_nxt;
                                `CRM_OP_MAC: ext_r <= ext_r + {4'h0, mac_prod};
                                `CRM_OP_CALL: begin
                                    // Return address is past the call itself
                                    program_counter_r <= program_counter_r
                                        + {14'h0000, reg_wdata[5:4]};
                                    kind_r <= K_CALL;
                                    step_r <= 4'h0;
                                    state_r <= ST_PUSH;
                                end
                                `CRM_OP_RET: begin
                                    kind_r <= K_RET;
                                    step_r <= `CRM_FRAME_CALL_TOP;
                                    phase_r <= 2'h0;
                                    state_r <= ST_PULL;
                                end
                                `CRM_OP_RTI: begin
                                    kind_r <= K_RTI;
                                    step_r <= `CRM_FRAME_INT_TOP;
                                    phase_r <= 2'h0;
                                    state_r <= ST_PULL;
                                end
                                `CRM_OP_STOP: begin
                                    osc_stop <= !flag_register_r[`CRM_CCR_S];
                                end
                                `CRM_OP_ADVANCE: begin
                                    // Length 0 read as 1: a byte is always consumed
                                    adv_len_r <= (reg_wdata[5:4] == 2'h0) ? 2'h1
                                                                         : reg_wdata[5:4];
                                    state_r <= ST_WAITQ;
                                end
                                default: ;
                            endcase
                        end
                    end else if (nonmaskable_request_pin_take || irq_take) begin
                        osc_stop <= 1'b0;
                        kind_r <= K_INT;
                        nonmaskable_request_pin_r <= nonmaskable_request_pin_take;
                        step_r <= 4'h0;
                        state_r <= ST_PUSH;
                    end
                end
                ST_PUSH: begin
                    stack_pointer_r <= stack_pointer_r - 16'h0001;
                    mem_addr <= stack_pointer_r - 16'h0001;
                    mem_wdata <= push_byte;
                    mem_wr <= 1'b1;
                    step_r <= step_r + 4'h1;
                    if (kind_r == K_CALL && step_r == `CRM_FRAME_CALL_TOP) begin
                        program_counter_r <= operand_r;
                        state_r <= ST_IDLE;
                    end else if (kind_r == K_INT && step_r == `CRM_FRAME_INT_TOP) begin
                        // Stacked masks keep their old values; set I, and X for a nonmaskable request, for the handler
                        flag_register_r[`CRM_CCR_I] <= 1'b1;
                        if (nonmaskable_request_pin_r) begin
                            flag_register_r[`CRM_CCR_X] <= 1'b1;
                        end
                        program_counter_r <= nonmaskable_request_pin_r ? NONMASKABLE_REQUEST_PIN_VECTOR : IRQ_VECTOR;
                        irq_ack <= 1'b1;
                        state_r <= ST_IDLE;
                    end
                end
                ST_PULL: begin
                    if (phase_r == 2'h0) begin
                        mem_addr <= stack_pointer_r;
                        mem_rd <= 1'b1;
                        phase_r <= 2'h1;
                    end else if (phase_r == 2'h1) begin
                        phase_r <= `CRM_PULL_CAPTURE;
                    end else begin
                        stack_pointer_r <= stack_pointer_r + 16'h0001;
                        phase_r <= 2'h0;
                        case (step_r)
                            4'h0: program_counter_r[7:0] <= mem_rdata;
                            4'h1: program_counter_r[15:8] <= mem_rdata;
                            4'h2: idx_y_r[7:0] <= mem_rdata;
                            4'h3: idx_y_r[15:8] <= mem_rdata;
                            4'h4: idx_x_r[7:0] <= mem_rdata;
                            4'h5: idx_x_r[15:8] <= mem_rdata;
                            4'h6: acc_a_r <= mem_rdata;
                            4'h7: acc_b_r <= mem_rdata;
                            default: flag_register_r <= {mem_rdata[7],
                                mem_rdata[6] & x_mask, mem_rdata[5:0]};
                        endcase
                        step_r <= step_r - 4'h1;
                        if (step_r == 4'h0) begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_WAITQ: begin
                    if (q_full) begin
                        program_counter_r <= program_counter_r
                            + {14'h0000, adv_len_r};
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

endmodule
`default_nettype wire

// ---- testbench/crm_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module crm_chk (
    input wire logic clock,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] mem_addr,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic irq_ack,
    input wire logic osc_stop,
    input wire logic code_ready
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    logic [3:0] run_r;
    logic wr_d_r;
    // Length of the latest unbroken push burst, held until the next one
    always @(posedge clock) begin
        wr_d_r <= mem_wr;
        if (rst)
            run_r <= 4'h0;
        else if (mem_wr)
            run_r <= wr_d_r ? run_r + 4'h1 : 4'h1;
    end
    a_push_addr_down:
        assert property (mem_wr && $past(mem_wr) |-> mem_addr == $past(mem_addr) - 16'h1)
        else $error("Push address did not step down by one");
    a_pull_addr_up:
        assert property (mem_rd && $past(mem_rd, 3) |-> mem_addr == $past(mem_addr, 3) + 16'h1)
        else $error("Pull address did not step up by one");
    a_pull_spacing:
        assert property (mem_rd |=> !mem_rd ##1 !mem_rd)
        else $error("Pulls closer than three cycles");
    a_frame_nine:
        assert property (irq_ack |=> run_r == 4'h9)
        else $error("Vector taken without a nine byte frame");
    a_ack_pulse:
        assert property (irq_ack |=> !irq_ack)
        else $error("Acknowledge longer than one cycle");
    a_mem_one_way:
        assert property (!(mem_wr && mem_rd))
        else $error("Push and pull in the same cycle");
    a_rdata_idle:
        assert property (!$past(reg_rd) |-> reg_rdata == 16'h0)
        else $error("Read data outside its cycle");
    a_reset_state:
        assert property ($fell(rst) |-> reg_rdata == 16'h0 && !osc_stop && !irq_ack && code_ready)
        else $error("Outputs not at rest after reset");
endmodule
bind crm_core crm_chk chk_u (
    .clock(clock),
    .rst(rst),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .mem_addr(mem_addr),
    .mem_wr(mem_wr),
    .mem_rd(mem_rd),
    .irq_ack(irq_ack),
    .osc_stop(osc_stop),
    .code_ready(code_ready)
);
`default_nettype wire

// ---- testbench/crm_mem_model.sv ----
`timescale 1ns/100ps
`default_nettype none
module crm_mem_model (
    input wire logic clock,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    input wire logic mem_wr,
    input wire logic mem_rd,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:65535];
    // Data valid one cycle only, then scrambled so a late sample shows up
    always @(posedge clock) begin
        if (mem_wr)
            mem[mem_addr] <= mem_wdata;
        if (mem_rd)
            mem_rdata <= mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
    end
endmodule
`default_nettype wire

// ---- testbench/cpu_programmer_register_model_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
`include "crm_map.vh"
module cpu_programmer_register_model_tb_top;
    typedef struct packed {
        logic [15:0] d;
        logic [15:0] opnd;
        logic [7:0] flag_register;
        logic [7:0] cmd;
        logic [15:0] exp_d;
        logic [7:0] exp_ccr;
        logic [15:0] exp_ea;
    } crm_row_t;
    crm_row_t rows [12] = '{
        '{16'h3a48, 16'h0, 8'hd0, 8'h00, 16'h8248, 8'hfa, 16'h0},
        '{16'hff01, 16'h0, 8'hd0, 8'h00, 16'h0001, 8'hf5, 16'h0},
        '{16'h1020, 16'h0, 8'hd0, 8'h01, 16'hf020, 8'hd9, 16'h0},
        '{16'h8001, 16'h0, 8'hd0, 8'h01, 16'h7f01, 8'hd2, 16'h0},
        '{16'h5555, 16'h0, 8'hd0, 8'h02, 16'h5555, 8'hd4, 16'h0},
        '{16'h0102, 16'h0, 8'hd0, 8'h02, 16'h0102, 8'hd9, 16'h0},
        '{16'h9a9a, 16'h0, 8'hd2, 8'h03, 16'h009a, 8'hd7, 16'h0},
        '{16'h8001, 16'h001f, 8'hd0, 8'h07, 16'h8001, 8'hd0, 16'h0fff},
        '{16'h8001, 16'h41a0, 8'hd0, 8'h07, 16'h8001, 8'hd0, 16'h0fa0},
        '{16'h8001, 16'h8040, 8'hd0, 8'h07, 16'h8001, 8'hd0, 16'ha040},
        '{16'h8001, 16'hc080, 8'hd0, 8'h07, 16'h8001, 8'hd0, 16'h1001},
        '{16'h8001, 16'hc140, 8'hd0, 8'h07, 16'h8001, 8'hd0, 16'ha001}};
    logic [7:0] fr [9] = '{8'hc0, 8'h44, 8'h33, 8'h11, 8'h11, 8'h22, 8'h22, 8'h56, 8'h78};
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_req = 1'b0;
    logic nonmaskable_request_pin_n = 1'b1;
    logic code_valid = 1'b0;
    logic [7:0] code_data = 8'h11;
    logic [15:0] ack_cnt = 16'h0000;
    int failures = 0;
    int compares = 0;
    wire [15:0] reg_rdata;
    wire [15:0] mem_addr;
    wire [7:0] mem_wdata;
    wire [7:0] mem_rdata;
    wire mem_wr;
    wire mem_rd;
    wire irq_ack;
    wire osc_stop;
    wire code_ready;
    always #25 clock = ~clock;
    crm_core DUT (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_addr(mem_addr),
        .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata),
        .irq_req(irq_req), .nonmaskable_request_pin_n(nonmaskable_request_pin_n),
        .irq_ack(irq_ack), .osc_stop(osc_stop), .code_data(code_data),
        .code_valid(code_valid), .code_ready(code_ready));
    crm_mem_model mem_u (.clock(clock), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
    always @(posedge clock) begin
        if (irq_ack === 1'b1)
            ack_cnt <= ack_cnt + 16'h1;
        if (code_valid && code_ready === 1'b1)
            code_data <= code_data + 8'h11;
    end
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        // Data stand one cycle only; taken at the edge that closes it
        @(posedge clock);
        d = reg_rdata;
    endtask
    task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
        logic [15:0] v;
        rd(a, v);
        check(v, exp);
    endtask
    task automatic run(input logic [7:0] c);
        logic [15:0] v;
        v = 16'h0001;
        wr(`CRM_REG_CMD, {8'h00, c});
        for (int i = 0; i < 40 && v[0] !== 1'b0; i++)
            rd(`CRM_REG_STATUS, v);
        check({15'h0, v[0]}, 16'h0000);
    endtask
    task automatic wait_ack(input logic [15:0] n);
        for (int i = 0; i < 60 && ack_cnt !== n; i++)
            @(posedge clock);
        check(ack_cnt, n);
    endtask
    task automatic report_and_stop;
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #2000000;
        failures++;
        report_and_stop;
    end
    initial begin
        logic [15:0] v;
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        rchk(`CRM_REG_CCR, 16'h00d0);
        rchk(5'h1f, 16'h0000);
        $display("Done: reset");
        wr(`CRM_REG_X, 16'h1000);
        wr(`CRM_REG_Y, 16'h2000);
        foreach (rows[i]) begin
            wr(`CRM_REG_D, rows[i].d);
            wr(`CRM_REG_CCR, {8'h00, rows[i].flag_register});
            wr(`CRM_REG_OPERAND, rows[i].opnd);
            run(rows[i].cmd);
            rchk(`CRM_REG_D, rows[i].exp_d);
            rchk(`CRM_REG_CCR, {8'h00, rows[i].exp_ccr});
            if (rows[i].cmd[3:0] == `CRM_OP_EA)
                rchk(`CRM_REG_EA, rows[i].exp_ea);
        end
        $display("Done: table");
        wr(`CRM_REG_SP, 16'h0800);
        wr(`CRM_REG_PC, 16'h1234);
        wr(`CRM_REG_OPERAND, 16'h4000);
        run(8'h34);
        check({8'h00, mem_u.mem[16'h07ff]}, 16'h0037);
        check({8'h00, mem_u.mem[16'h07fe]}, 16'h0012);
        rchk(`CRM_REG_SP, 16'h07fe);
        rchk(`CRM_REG_PC, 16'h4000);
        run(8'h05);
        rchk(`CRM_REG_PC, 16'h1237);
        rchk(`CRM_REG_SP, 16'h0800);
        $display("Done: call");
        wr(`CRM_REG_D, 16'h3344);
        wr(`CRM_REG_X, 16'h1111);
        wr(`CRM_REG_Y, 16'h2222);
        wr(`CRM_REG_SP, 16'h0900);
        wr(`CRM_REG_PC, 16'h5678);
        irq_req <= 1'b1;
        repeat (20) @(posedge clock);
        check(ack_cnt, 16'h0000);
        wr(`CRM_REG_CCR, 16'h00c0);
        wait_ack(16'h0001);
        irq_req <= 1'b0;
        for (int k = 0; k < 9; k++)
            check({8'h00, mem_u.mem[16'h08f7 + k]}, {8'h00, fr[k]});
        rchk(`CRM_REG_PC, 16'hfff0);
        rchk(`CRM_REG_CCR, 16'h00d0);
        wr(`CRM_REG_X, 16'h0000);
        wr(`CRM_REG_Y, 16'h0000);
        run(8'h06);
        rchk(`CRM_REG_X, 16'h1111);
        rchk(`CRM_REG_Y, 16'h2222);
        rchk(`CRM_REG_PC, 16'h5678);
        rchk(`CRM_REG_CCR, 16'h00c0);
        $display("Done: interrupt");
        run(8'h08);
        check({15'h0, osc_stop}, 16'h0000);
        nonmaskable_request_pin_n <= 1'b0;
        repeat (20) @(posedge clock);
        check(ack_cnt, 16'h0001);
        nonmaskable_request_pin_n <= 1'b1;
        wr(`CRM_REG_CCR, 16'h0010);
        run(8'h08);
        check({15'h0, osc_stop}, 16'h0001);
        wr(`CRM_REG_D, 16'hbeef);
        nonmaskable_request_pin_n <= 1'b0;
        wait_ack(16'h0002);
        nonmaskable_request_pin_n <= 1'b1;
        check({15'h0, osc_stop}, 16'h0000);
        rchk(`CRM_REG_PC, 16'hfff8);
        rchk(`CRM_REG_CCR, 16'h0050);
        check({8'h00, mem_u.mem[16'h08f7]}, 16'h0010);
        rchk(`CRM_REG_D, 16'h3344);
        run(8'h06);
        wr(`CRM_REG_CCR, 16'h00d0);
        rchk(`CRM_REG_CCR, 16'h0090);
        $display("Done: stop");
        code_valid <= 1'b1;
        repeat (8) @(posedge clock);
        check({15'h0, code_ready}, 16'h0000);
        rchk(`CRM_REG_STATUS, 16'h000c);
        rchk(`CRM_REG_QUEUE_LO, 16'h2211);
        rd(`CRM_REG_PC, v);
        run(8'h19);
        rchk(`CRM_REG_PC, v + 16'h0001);
        run(8'h39);
        rchk(`CRM_REG_PC, v + 16'h0004);
        $display("Done: queue");
        wr(`CRM_REG_D, 16'hffff);
        repeat (3) run(8'h0a);
        rchk(`CRM_REG_EXT_LO, 16'hfa03);
        rchk(`CRM_REG_EXT_HI, 16'h0002);
        $display("Done: extended");
        report_and_stop;
    end
endmodule
`default_nettype wire
